// ===== include/tmc_map.svh
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
// Register addresses.
`define TMC_A_MODE 8'h89
`define TMC_A_T0L 8'h8a
`define TMC_A_T1L 8'h8b
`define TMC_A_T0H 8'h8c
`define TMC_A_T1H 8'h8d
`define TMC_A_AUX 8'ha3
`define TMC_A_T2CTL 8'hc8
`define TMC_A_T2MOD 8'hc9
`define TMC_A_CRL 8'hca
`define TMC_A_CRH 8'hcb
`define TMC_A_T2L 8'hcc
`define TMC_A_T2H 8'hcd
`define TMC_A_T01RUN 8'h88
// Reset value and count constants.
`define TMC_RST8 8'h00
`define TMC_ONES8 8'hff
`define TMC_ONES16 16'hffff
`define TMC_ONE8 8'h01
`define TMC_ONE16 16'h0001
// Field positions and the T2MOD write mask.
`define TMC_AUX_X12_1 3
`define TMC_AUX_X12_0 2
`define TMC_AUX_CKO_1 1
`define TMC_AUX_CKO_0 0
`define TMC_MOD_POL 5
`define TMC_MOD_X12 4
`define TMC_MOD_CKO 1
`define TMC_MOD_DOWN_COUNT_ENABLE 0
`define TMC_MOD_MASK 8'h33
// Prescale counts.
`define TMC_DIV12 4'd11
`define TMC_DIV2 4'd1
`define TMC_DIV_W 4
`endif

// ===== include/tmc_pkg.sv
package tmc_pkg;
	typedef struct packed {
		logic gate;
		logic cnt_sel;
		logic mode_field_high;
		logic mode_field_low;
	} tmc_tmode_t;
	typedef struct packed {
		tmc_tmode_t t1;
		tmc_tmode_t t0;
	} tmc_mode_t;
	typedef struct packed {
		logic overflow_flag_two;
		logic external_event_flag;
		logic receive_clock_select;
		logic transmit_clock_select;
		logic trigger_pin_enable;
		logic run_bit_two;
		logic counter_select_two;
		logic capture_select;
	} tmc_t2ctl_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmc_sfr_t;
	typedef enum logic [1:0] {TMC_T2_CAP, TMC_T2_RLD, TMC_T2_UPDN,
		TMC_T2_BAUD} tmc_t2mode_t;
endpackage

// ===== verilog/tmc_sync_edge.sv
`default_nettype none
// Two-flop synchroniser with one edge-detect stage after it.
module tmc_sync_edge (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_pin,
	output logic o_level,
	output logic o_fall,
	output logic o_rise
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign o_level = s2_q;
	assign o_fall = s3_q & ~s2_q;
	assign o_rise = ~s3_q & s2_q;
endmodule
`default_nettype wire

// ===== verilog/tmc_prescale.sv
`default_nettype none
`include "tmc_map.svh"
// Free-running divider giving a one-cycle tick every i_top+1 clocks.
module tmc_prescale (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic [`TMC_DIV_W-1:0] i_top,
	output logic o_tick
);
	logic [`TMC_DIV_W-1:0] cnt_q;
	logic [`TMC_DIV_W-1:0] cnt_d;
	wire at_top = (cnt_q >= i_top);
	assign cnt_d = at_top ? '0 : cnt_q + 1'b1;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	assign o_tick = at_top;
endmodule
`default_nettype wire

// ===== verilog/tmc_timers.sv
// Notes on behaviour
// [RQ1] Gate set: count needs run bit and pin high.
// [RQ2] Counter select picks prescaled clock or pin.
// [RQ3] Modes: 13-bit, 16-bit, 8-bit reload, special.
// [RQ4] Mode 3: timer 1 holds, timer 0 splits.
// [RQ5] Fast-clock bit picks divide-by-12 or undivided.
// [RQ6] Clock-out enables drive toggling timer clocks out.
// [RQ7] Timer 2: 16-bit, four modes, timer/counter select.
// [RQ8] Capture mode overflow sets overflow flag.
// [RQ9] Capture on trigger edge, sets event flag.
// [RQ10] Event flag shares timer 2 interrupt request.
// [RQ11] Up reload: overflow sets flag, reloads.
// [RQ12] Up reload: trigger edge also reloads, sets flag.
// [RQ13] Up reload: either flag requests interrupt.
// [RQ14] Up/down, pin high: count up, reload on overflow.
// [RQ15] Up/down, pin low: down, match loads all ones.
// [RQ16] Up/down: event flag toggles, no interrupt.
// [RQ17] Transmit and receive baud sources chosen independently.
// [RQ18] Baud mode: rollover reloads from capture bytes.
// [RQ19] Baud mode: rollover sets no flag, no interrupt.
// [RQ20] Baud mode: trigger edge sets flag, no reload.
// [RQ21] Baud mode counts at half clock or pin; with TMC_MOD_X12 set the code counts every clock.
// [RQ22] Software stops timer 2 before accessing it.
// [RQ23] 13/16-bit rollover sets overflow flag.
// [RQ24] 8-bit mode: low reloads from high.
// [RQ25] Counter input counts sampled high-then-low.
// [RQ26] Polarity bit picks falling or rising trigger edge.
// [RQ27] One-cycle baud tick per baud-mode rollover.
`default_nettype none
`include "tmc_map.svh"
module tmc_timers
	import tmc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire tmc_pkg::tmc_sfr_t i_sfr,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	input wire logic i_t0_pin,
	input wire logic i_t1_pin,
	input wire logic i_t2_pin,
	input wire logic i_ext_irq_pin_zero,
	input wire logic i_ext_irq_pin_one,
	input wire logic i_trigger_pin,
	input wire logic i_t1_ovf_clear,
	output logic o_t0_ovf,
	output logic o_t1_ovf,
	output logic o_t2_irq,
	output logic o_t0_clk_out,
	output logic o_t0_clk_out_en,
	output logic o_t1_clk_out,
	output logic o_t1_clk_out_en,
	output logic o_tx_baud_tick,
	output logic o_rx_baud_tick
);
	import tmc_pkg::*;

	tmc_mode_t mode_q;
	logic [7:0] aux_q;
	logic [7:0] c0l_q, c0h_q, c1l_q, c1h_q;
	logic run_bit_zero_q, run_bit_one_q, ovf0_q, ovf1_q;
	tmc_t2ctl_t t2c_q;
	logic [7:0] t2mod_q;
	logic [15:0] cnt2_q;
	logic [15:0] crl_q;
	logic cko0_q, cko1_q, txb_q, rxb_q;

	// Shared prescalers: one divide-by-12 for classic timers, one for
	// the baud-mode half clock.
	logic tick12, tick2;
	tmc_prescale u_div12 (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_top(`TMC_DIV12), .o_tick(tick12));
	tmc_prescale u_div2 (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_top(`TMC_DIV2), .o_tick(tick2));

	logic t0_lvl, t0_fall, t1_lvl, t1_fall, t2_lvl, t2_fall;
	logic g0_lvl, g1_lvl, ex_lvl, ex_fall, ex_rise;
	tmc_sync_edge u_s0 (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_pin(i_t0_pin), .o_level(t0_lvl), .o_fall(t0_fall), .o_rise());
	tmc_sync_edge u_s1 (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_pin(i_t1_pin), .o_level(t1_lvl), .o_fall(t1_fall), .o_rise());
	tmc_sync_edge u_s2 (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_pin(i_t2_pin), .o_level(t2_lvl), .o_fall(t2_fall), .o_rise());
	tmc_sync_edge u_g0 (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_pin(i_ext_irq_pin_zero), .o_level(g0_lvl), .o_fall(),
		.o_rise());
	tmc_sync_edge u_g1 (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_pin(i_ext_irq_pin_one), .o_level(g1_lvl), .o_fall(),
		.o_rise());
	tmc_sync_edge u_ex (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_pin(i_trigger_pin), .o_level(ex_lvl), .o_fall(ex_fall),
		.o_rise(ex_rise));

	function automatic logic wr_at(input tmc_sfr_t b, input logic [7:0] a);
		wr_at = b.wr && (b.addr == a);
	endfunction

	// Count strobe: internal prescaled tick or a sampled pin fall.
	// The tick is an argument so that callers re-evaluate when it moves.
	function automatic logic cnt_src(input logic csel, input logic fast,
		input logic fall, input logic tick);
		cnt_src = csel ? fall : (fast | tick);
	endfunction

	// Timer 0 and 1 strobes.
	wire gate0 = run_bit_zero_q & (~mode_q.t0.gate | g0_lvl); // see [RQ1]
	wire gate1 = run_bit_one_q & (~mode_q.t1.gate | g1_lvl); // see [RQ1]
	wire [1:0] m0 = {mode_q.t0.mode_field_high, mode_q.t0.mode_field_low};
	wire [1:0] m1 = {mode_q.t1.mode_field_high, mode_q.t1.mode_field_low};
	wire src0 = cnt_src(mode_q.t0.cnt_sel, aux_q[`TMC_AUX_X12_0],
		t0_fall, tick12); // see [RQ2] [RQ5] [RQ25]
	wire src1 = cnt_src(mode_q.t1.cnt_sel, aux_q[`TMC_AUX_X12_1],
		t1_fall, tick12); // see [RQ2] [RQ5] [RQ25]
	wire inc0 = gate0 & src0;
	// In split mode the high byte of timer 0 borrows timer 1's run bit
	// and counts only internal clocks.
	wire split = (m0 == 2'b11);
	wire inc0h = split & run_bit_one_q &
		(aux_q[`TMC_AUX_X12_1] | tick12); // see [RQ4]
	wire inc1 = gate1 & src1 & (m1 != 2'b11); // see [RQ4]

	logic [7:0] n0l, n0h, n1l, n1h;
	logic ov0, ov1, ov0h;
	always_comb begin
		n0l = c0l_q;
		n0h = c0h_q;
		ov0 = 1'b0;
		ov0h = 1'b0;
		if (inc0) begin
			case (m0) // see [RQ3]
			2'b00: begin
				// 13-bit: five low bits of the low byte below the high byte.
				{ov0, n0h, n0l[4:0]} = {1'b0, c0h_q, c0l_q[4:0]} +
					14'h0001; // see [RQ23]
			end
			2'b01: begin
				{ov0, n0h, n0l} = {1'b0, c0h_q, c0l_q} + 17'h00001; // see [RQ23]
			end
			2'b10: begin
				ov0 = (c0l_q == `TMC_ONES8);
				n0l = ov0 ? c0h_q : c0l_q + `TMC_ONE8; // see [RQ24]
			end
			default: begin
				ov0 = (c0l_q == `TMC_ONES8);
				n0l = c0l_q + `TMC_ONE8; // see [RQ4]
			end
			endcase
		end
		if (inc0h) begin
			ov0h = (c0h_q == `TMC_ONES8);
			n0h = c0h_q + `TMC_ONE8;
		end
	end
	always_comb begin
		n1l = c1l_q;
		n1h = c1h_q;
		ov1 = 1'b0;
		if (inc1) begin
			case (m1) // see [RQ3]
			2'b00: begin
				{ov1, n1h, n1l[4:0]} = {1'b0, c1h_q, c1l_q[4:0]} +
					14'h0001; // see [RQ23]
			end
			2'b01: begin
				{ov1, n1h, n1l} = {1'b0, c1h_q, c1l_q} + 17'h00001; // see [RQ23]
			end
			default: begin
				ov1 = (c1l_q == `TMC_ONES8);
				n1l = ov1 ? c1h_q : c1l_q + `TMC_ONE8; // see [RQ24]
			end
			endcase
		end
	end

	// Timer 2 mode decode.
	wire baud = t2c_q.receive_clock_select | t2c_q.transmit_clock_select;
	wire down_count_enable = t2mod_q[`TMC_MOD_DOWN_COUNT_ENABLE];
	tmc_t2mode_t t2m;
	assign t2m = baud ? TMC_T2_BAUD : t2c_q.capture_select ? TMC_T2_CAP :
		down_count_enable ? TMC_T2_UPDN : TMC_T2_RLD; // see [RQ7]
	wire t2_fast = t2mod_q[`TMC_MOD_X12];
	wire t2_int = baud ? (t2_fast | tick2) : (t2_fast | tick12); // see [RQ21]
	wire inc2 = t2c_q.run_bit_two &
		(t2c_q.counter_select_two ? t2_fall : t2_int); // see [RQ7]
	wire trig_edge = t2mod_q[`TMC_MOD_POL] ? ex_rise : ex_fall; // see [RQ26]
	wire trig = trig_edge & t2c_q.trigger_pin_enable;
	wire up = (t2m != TMC_T2_UPDN) | ex_lvl; // see [RQ14] [RQ15]
	wire top2 = (cnt2_q == `TMC_ONES16);
	wire match2 = (cnt2_q == crl_q);
	wire ovf2 = inc2 & up & top2;
	wire unf2 = inc2 & ~up & match2;

	logic [15:0] n2;
	logic [15:0] ncrl;
	logic set_tf2, set_ex, tog_ex;
	always_comb begin
		n2 = cnt2_q;
		ncrl = crl_q;
		set_tf2 = 1'b0;
		set_ex = 1'b0;
		tog_ex = 1'b0;
		if (inc2) begin
			n2 = up ? cnt2_q + `TMC_ONE16 : cnt2_q - `TMC_ONE16;
		end
		case (t2m)
		TMC_T2_CAP: begin
			set_tf2 = ovf2; // see [RQ8]
			if (trig) begin
				ncrl = n2; // see [RQ9]
				set_ex = 1'b1;
			end
		end
		TMC_T2_RLD: begin
			set_tf2 = ovf2; // see [RQ11]
			set_ex = trig; // see [RQ12]
			if (ovf2 | trig) begin
				n2 = crl_q; // see [RQ11] [RQ12]
			end
		end
		TMC_T2_UPDN: begin
			set_tf2 = ovf2 | unf2;
			tog_ex = ovf2 | unf2; // see [RQ16]
			if (ovf2) begin
				n2 = crl_q; // see [RQ14]
			end else if (unf2) begin
				n2 = `TMC_ONES16; // see [RQ15]
			end
		end
		default: begin
			set_ex = trig; // see [RQ20]
			if (ovf2) begin
				n2 = crl_q; // see [RQ18] [RQ19]
			end
		end
		endcase
	end

	// Bus writes and flag clears; hardware sets win over software clears.
	wire [7:0] wd = i_sfr.wdata;
	tmc_t2ctl_t t2w;
	assign t2w = tmc_t2ctl_t'(wd);
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mode_q <= tmc_mode_t'(`TMC_RST8);
			aux_q <= `TMC_RST8;
			c0l_q <= `TMC_RST8;
			c0h_q <= `TMC_RST8;
			c1l_q <= `TMC_RST8;
			c1h_q <= `TMC_RST8;
			run_bit_zero_q <= 1'b0;
			run_bit_one_q <= 1'b0;
			ovf0_q <= 1'b0;
			ovf1_q <= 1'b0;
			t2c_q <= tmc_t2ctl_t'(`TMC_RST8);
			t2mod_q <= `TMC_RST8;
			cnt2_q <= '0;
			crl_q <= '0;
		end else begin
			mode_q <= wr_at(i_sfr, `TMC_A_MODE) ? tmc_mode_t'(wd) : mode_q;
			aux_q <= wr_at(i_sfr, `TMC_A_AUX) ? wd : aux_q;
			t2mod_q <= wr_at(i_sfr, `TMC_A_T2MOD) ?
				(wd & `TMC_MOD_MASK) : t2mod_q;
			c0l_q <= wr_at(i_sfr, `TMC_A_T0L) ? wd : n0l;
			c0h_q <= wr_at(i_sfr, `TMC_A_T0H) ? wd : n0h;
			c1l_q <= wr_at(i_sfr, `TMC_A_T1L) ? wd : n1l;
			c1h_q <= wr_at(i_sfr, `TMC_A_T1H) ? wd : n1h;
			if (wr_at(i_sfr, `TMC_A_T01RUN)) begin
				run_bit_one_q <= wd[6];
				run_bit_zero_q <= wd[4];
			end
			ovf0_q <= ov0 | (ovf0_q &
				~(wr_at(i_sfr, `TMC_A_T01RUN) & ~wd[5])); // see [RQ23]
			ovf1_q <= ov1 | ov0h | (ovf1_q & ~i_t1_ovf_clear &
				~(wr_at(i_sfr, `TMC_A_T01RUN) & ~wd[7]));
			// Counting and software writes collide only if software ignores
			// the advice to stop timer 2 first; the write then wins.
			cnt2_q[7:0] <= wr_at(i_sfr, `TMC_A_T2L) ? wd : n2[7:0]; // see [RQ22]
			cnt2_q[15:8] <= wr_at(i_sfr, `TMC_A_T2H) ? wd : n2[15:8];
			crl_q[7:0] <= wr_at(i_sfr, `TMC_A_CRL) ? wd : ncrl[7:0];
			crl_q[15:8] <= wr_at(i_sfr, `TMC_A_CRH) ? wd : ncrl[15:8];
			if (wr_at(i_sfr, `TMC_A_T2CTL)) begin
				t2c_q <= t2w;
				t2c_q.overflow_flag_two <= t2w.overflow_flag_two | set_tf2;
				t2c_q.external_event_flag <= set_ex |
					(t2w.external_event_flag ^ tog_ex);
			end else begin
				t2c_q.overflow_flag_two <= t2c_q.overflow_flag_two | set_tf2;
				t2c_q.external_event_flag <= set_ex |
					(t2c_q.external_event_flag ^ tog_ex);
			end
		end
	end

	// Clock outputs toggle on each overflow for a 50% duty square wave.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cko0_q <= 1'b0;
			cko1_q <= 1'b0;
			txb_q <= 1'b0;
			rxb_q <= 1'b0;
		end else begin
			cko0_q <= cko0_q ^ ov0;
			cko1_q <= cko1_q ^ ov1;
			txb_q <= t2c_q.transmit_clock_select ? (ovf2 & baud) : ov1; // see [RQ17] [RQ27]
			rxb_q <= t2c_q.receive_clock_select ? (ovf2 & baud) : ov1; // see [RQ17] [RQ27]
		end
	end
	assign o_t0_clk_out = cko0_q;
	assign o_t1_clk_out = cko1_q;
	assign o_t0_clk_out_en = aux_q[`TMC_AUX_CKO_0] & ~mode_q.t0.cnt_sel; // see [RQ6]
	assign o_t1_clk_out_en = aux_q[`TMC_AUX_CKO_1] & ~mode_q.t1.cnt_sel; // see [RQ6]
	assign o_tx_baud_tick = txb_q;
	assign o_rx_baud_tick = rxb_q;
	assign o_t0_ovf = ovf0_q;
	assign o_t1_ovf = ovf1_q;
	// The event flag joins the overflow flag except in up/down mode.
	assign o_t2_irq = t2c_q.overflow_flag_two | (t2c_q.external_event_flag &
		(t2m != TMC_T2_UPDN)); // see [RQ10] [RQ13] [RQ16]

	// Read data is registered; unmapped addresses read zero.
	logic [7:0] rsel;
	always_comb begin
		case (i_sfr.addr)
		`TMC_A_MODE: rsel = mode_q;
		`TMC_A_T0L: rsel = c0l_q;
		`TMC_A_T1L: rsel = c1l_q;
		`TMC_A_T0H: rsel = c0h_q;
		`TMC_A_T1H: rsel = c1h_q;
		`TMC_A_AUX: rsel = aux_q;
		`TMC_A_T01RUN: rsel = {ovf1_q, run_bit_one_q, ovf0_q, run_bit_zero_q,
			4'h0};
		`TMC_A_T2CTL: rsel = t2c_q;
		`TMC_A_T2MOD: rsel = t2mod_q;
		`TMC_A_CRL: rsel = crl_q[7:0];
		`TMC_A_CRH: rsel = crl_q[15:8];
		`TMC_A_T2L: rsel = cnt2_q[7:0];
		`TMC_A_T2H: rsel = cnt2_q[15:8];
		default: rsel = `TMC_RST8;
		endcase
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= `TMC_RST8;
			o_rvalid <= 1'b0;
		end else begin
			o_rdata <= i_sfr.rd ? rsel : o_rdata;
			o_rvalid <= i_sfr.rd;
		end
	end
endmodule
`default_nettype wire

// ===== test/tmc_timers_sva.sv
`default_nettype none
module tmc_timers_sva import tmc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire tmc_pkg::tmc_sfr_t i_sfr,
	input wire logic i_t1_ovf_clear,
	input wire logic o_rvalid,
	input wire logic o_t0_ovf,
	input wire logic o_t1_ovf,
	input wire logic o_t2_irq,
	input wire logic o_t0_clk_out_en,
	input wire logic o_t1_clk_out_en,
	input wire logic o_tx_baud_tick,
	input wire logic o_rx_baud_tick
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	read_answer_a: assert property (i_sfr.rd |=> o_rvalid)
		else $error("read not answered");
	// Baud mode counts at half rate when TMC_MOD_X12 is clear, so its ticks never abut.
	tx_tick_a: assert property (
		o_tx_baud_tick |=> !o_tx_baud_tick) else $error("tx tick long");
	rx_tick_a: assert property (
		o_rx_baud_tick |=> !o_rx_baud_tick) else $error("rx tick long");
	t0_cko_en_a: assert property (
		!i_sfr.wr |=> $stable(o_t0_clk_out_en)) else $error("t0 cko");
	t1_cko_en_a: assert property (
		!i_sfr.wr |=> $stable(o_t1_clk_out_en)) else $error("t1 cko");
	t0_flag_hold_a: assert property (
		$fell(o_t0_ovf) |-> $past(i_sfr.wr)) else $error("t0 flag lost");
	t1_flag_hold_a: assert property (
		$fell(o_t1_ovf) |-> $past(i_sfr.wr) || $past(i_t1_ovf_clear))
		else $error("t1 flag lost");
	t2_req_hold_a: assert property (
		$fell(o_t2_irq) |-> $past(i_sfr.wr)) else $error("t2 req lost");
	cover property (o_tx_baud_tick);
	cover property ($rose(o_t2_irq));
	cover property ($rose(o_t0_ovf));
endmodule
`default_nettype wire

// ===== test/tmc_cpu_model.sv
`default_nettype none
module tmc_cpu_model import tmc_pkg::*; (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	output var tmc_pkg::tmc_sfr_t o_sfr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_sfr = '0;
	// Idle address and data are inverted so stale values never pass.
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_clk);
		o_sfr = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge i_clk);
		d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
		o_sfr = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
	endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic irq0 = 1'b1;
	logic trig = 1'b1;
	logic ovf_clr = 1'b0;
	logic t0p = 1'b1;
	logic cko0;
	tmc_pkg::tmc_sfr_t sfr;
	logic [7:0] rdata;
	logic [7:0] v;
	logic rvalid, t0_ovf, t1_ovf, t2_irq, txt, rxt, t0en, t1en;
	int fails = 0;
	int comparisons = 0;
	tmc_timers tmc_timers_i (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr(sfr), .o_rdata(rdata),
		.o_rvalid(rvalid), .i_t0_pin(t0p), .i_t1_pin(1'b1),
		.i_t2_pin(1'b1), .i_ext_irq_pin_zero(irq0),
		.i_ext_irq_pin_one(1'b1), .i_trigger_pin(trig),
		.i_t1_ovf_clear(ovf_clr), .o_t0_ovf(t0_ovf), .o_t1_ovf(t1_ovf),
		.o_t2_irq(t2_irq), .o_t0_clk_out(cko0), .o_t0_clk_out_en(t0en),
		.o_t1_clk_out(), .o_t1_clk_out_en(t1en), .o_tx_baud_tick(txt),
		.o_rx_baud_tick(rxt)
	);
	tmc_cpu_model tmc_cpu_model_i (
		.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_sfr(sfr)
	);
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		tmc_cpu_model_i.sfr_write(a, d);
	endtask
	task automatic r(input logic [7:0] a, output logic [7:0] d);
		tmc_cpu_model_i.sfr_read(a, d);
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic regs();
		logic [7:0] ra [6];
		ra = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha3};
		foreach (ra[k]) begin
			r(ra[k], v);
			chk(v, 8'h00);
		end
		w(8'h89, 8'h5a);
		r(8'h89, v);
		chk(v, 8'h5a);
		r(8'h90, v);
		chk(v, 8'h00);
		w(8'h89, 8'h00);
		w(8'ha3, 8'h03);
		chk({6'h00, t1en, t0en}, 8'h03);
		w(8'h89, 8'h44);
		chk({6'h00, t1en, t0en}, 8'h00);
		w(8'ha3, 8'h00);
	endtask
	// Undivided clock: at divide-by-12 the 20-cycle wait would run out.
	task automatic roll16();
		w(8'h89, 8'h11);
		w(8'ha3, 8'h0c);
		w(8'h8a, 8'hfd);
		w(8'h8c, 8'hff);
		w(8'h8b, 8'hfd);
		w(8'h8d, 8'hff);
		w(8'h88, 8'h50);
		repeat (20) if (!(t0_ovf && t1_ovf)) @(negedge i_clk);
		chk({6'h00, t1_ovf, t0_ovf}, 8'h03);
		chk({7'h00, cko0}, 8'h01);
		ovf_clr = 1'b1;
		@(negedge i_clk);
		ovf_clr = 1'b0;
		chk({7'h00, t1_ovf}, 8'h00);
		w(8'h88, 8'h00);
		r(8'h8c, v);
		chk(v, 8'h00);
	endtask
	task automatic gate();
		w(8'h89, 8'h09);
		w(8'h8a, 8'hff);
		w(8'h8c, 8'hff);
		irq0 = 1'b0;
		w(8'h88, 8'h10);
		repeat (20) @(negedge i_clk);
		chk({7'h00, t0_ovf}, 8'h00);
		irq0 = 1'b1;
		repeat (20) if (!t0_ovf) @(negedge i_clk);
		chk({7'h00, t0_ovf}, 8'h01);
		w(8'h88, 8'h00);
	endtask
	// Timer 1 parked in mode 3, so only the borrowed high byte sets its flag.
	task automatic split();
		w(8'h89, 8'h33);
		w(8'h8a, 8'hff);
		w(8'h8c, 8'hfe);
		w(8'h88, 8'h50);
		repeat (20) if (!(t0_ovf && t1_ovf)) @(negedge i_clk);
		chk({6'h00, t1_ovf, t0_ovf}, 8'h03);
		w(8'h88, 8'h00);
	endtask
	task automatic cnt_pin();
		w(8'h89, 8'h05);
		w(8'h8a, 8'h00);
		w(8'h88, 8'h10);
		repeat (3) begin
			t0p = 1'b0;
			repeat (4) @(negedge i_clk);
			t0p = 1'b1;
			repeat (4) @(negedge i_clk);
		end
		w(8'h88, 8'h00);
		r(8'h8a, v);
		chk(v, 8'h03);
	endtask
	task automatic reload8();
		w(8'h89, 8'h02);
		w(8'h8c, 8'h80);
		w(8'h8a, 8'hfe);
		w(8'h88, 8'h10);
		repeat (20) if (!t0_ovf) @(negedge i_clk);
		w(8'h88, 8'h00);
		r(8'h8c, v);
		chk(v, 8'h80);
		r(8'h8a, v);
		chk(v & 8'h80, 8'h80);
	endtask
	task automatic t2_up();
		w(8'hca, 8'h34);
		w(8'hcb, 8'h12);
		w(8'hcc, 8'hfe);
		w(8'hcd, 8'hff);
		w(8'hc9, 8'h10);
		w(8'hc8, 8'h04);
		repeat (20) if (!t2_irq) @(negedge i_clk);
		chk({7'h00, t2_irq}, 8'h01);
		w(8'hc8, 8'h00);
		chk({7'h00, t2_irq}, 8'h00);
		r(8'hcd, v);
		chk(v, 8'h12);
	endtask
	task automatic t2_baud();
		for (int k = 0; k < 2; k++) begin
			w(8'hcc, 8'hfe);
			w(8'hcd, 8'hff);
			w(8'hc8, k ? 8'h24 : 8'h14);
			repeat (20) if (!(txt || rxt)) @(negedge i_clk);
			chk({6'h00, rxt, txt}, k ? 8'h02 : 8'h01);
			chk({7'h00, t2_irq}, 8'h00);
			w(8'hc8, 8'h00);
			r(8'hcd, v);
			chk(v, 8'h12);
		end
	endtask
	task automatic t2_capt();
		w(8'hcc, 8'h00);
		w(8'hcd, 8'h00);
		w(8'hc8, 8'h0d);
		trig = 1'b0;
		repeat (20) if (!t2_irq) @(negedge i_clk);
		chk({7'h00, t2_irq}, 8'h01);
		r(8'hc8, v);
		chk(v & 8'hc0, 8'h40);
		w(8'hc8, 8'h00);
		r(8'hcb, v);
		chk(v, 8'h00);
		trig = 1'b1;
	endtask
	task automatic t2_updn();
		w(8'hc9, 8'h11);
		w(8'hca, 8'h34);
		w(8'hcb, 8'h12);
		w(8'hcc, 8'h36);
		w(8'hcd, 8'h12);
		trig = 1'b0;
		w(8'hc8, 8'h04);
		repeat (20) if (!t2_irq) @(negedge i_clk);
		chk({7'h00, t2_irq}, 8'h01);
		r(8'hc8, v);
		chk(v & 8'hc0, 8'hc0);
		w(8'hc8, 8'h00);
		r(8'hcd, v);
		chk(v, 8'hff);
	endtask
	initial begin
		repeat (2) @(negedge i_clk);
		i_arst_n = 1'b1;
		regs();
		roll16();
		gate();
		split();
		cnt_pin();
		reload8();
		t2_up();
		t2_baud();
		t2_capt();
		t2_updn();
		wrap_up();
	end
	// The whole sequence needs at most about 380 cycles.
	initial begin
		#100000;
		fails++;
		wrap_up();
	end
endmodule
bind tmc_timers tmc_timers_sva tmc_timers_sva_i (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr(i_sfr),
	.i_t1_ovf_clear(i_t1_ovf_clear), .o_rvalid(o_rvalid),
	.o_t0_ovf(o_t0_ovf), .o_t1_ovf(o_t1_ovf), .o_t2_irq(o_t2_irq),
	.o_t0_clk_out_en(o_t0_clk_out_en), .o_t1_clk_out_en(o_t1_clk_out_en),
	.o_tx_baud_tick(o_tx_baud_tick), .o_rx_baud_tick(o_rx_baud_tick)
);
`default_nettype wire
